// file: eeprom_front_end_pkg.sv
// constants, types and states for the two-wire memory client front end
// assumes a 250 mhz system clock and a host-driven serial clock on a pin
package eeprom_front_end_pkg;

    // device-type code is arbitrary here, set to suit the system
    localparam logic [3:0] DEVICE_TYPE_CODE = 4'h6;

    localparam int ADDR_W      = 15;
    localparam int PAGE_BITS   = 6;
    localparam int BIT_LAST    = 7;
    localparam int TIMER_W     = 21;
    localparam int FIFO_DEPTH  = 4;

    // control byte fields
    localparam int CTRL_TYPE_MSB = 7;
    localparam int CTRL_TYPE_LSB = 4;
    localparam int CTRL_CS_HIGH  = 3;
    localparam int CTRL_CS_MID   = 2;
    localparam int CTRL_CS_LOW   = 1;
    localparam int CTRL_RW       = 0;

    // synchroniser lanes
    localparam int SYNC_W       = 7;
    localparam int LANE_SCL     = 0;
    localparam int LANE_SDA     = 1;
    localparam int LANE_CS_LOW  = 2;
    localparam int LANE_CS_MID  = 3;
    localparam int LANE_CS_HIGH = 4;
    localparam int LANE_WP      = 5;
    localparam int LANE_SINGLE  = 6;

    // internal write cycle, longest time; the count is exact, 1250000 clocks
    localparam int WRITE_CYCLE_MS   = 5;
    localparam int CLK_FREQ_KHZ     = 250000;
    localparam int WRITE_CYCLE_CLKS = WRITE_CYCLE_MS * CLK_FREQ_KHZ;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_ACK,
        ST_SEND,
        ST_HOST_ACK
    } bus_state_t;

    typedef enum logic [1:0] {
        K_CTRL,
        K_ADDR_HI,
        K_ADDR_LO,
        K_DATA
    } byte_kind_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } wr_word_t;

endpackage : eeprom_front_end_pkg

// file: eeprom_front_end_properties.sv
// port checker for the two-wire client front end
// assumes one clk_sys domain; bound to every front end instance
`timescale 1ns/100ps
`default_nettype none
module eeprom_front_end_properties #(
    parameter logic [eeprom_front_end_pkg::TIMER_W-1:0] WRITE_CYCLE_CLKS =
        eeprom_front_end_pkg::TIMER_W'(eeprom_front_end_pkg::WRITE_CYCLE_CLKS)
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic read_load,
    input wire logic write_commit,
    input wire logic write_discard,
    input wire logic busy
);
    logic [eeprom_front_end_pkg::TIMER_W-1:0] busy_cnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            busy_cnt <= '0;
        else
            busy_cnt <= busy ? busy_cnt + 1'b1 : '0;
    end
    a_drain_only_low: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line moved with clock high");
    a_busy_no_ack: assert property ($rose(sda_oe) |-> !busy)
        else $error("pull while busy");
    a_commit_busy: assert property (write_commit |=> busy [*8])
        else $error("no busy after commit");
    a_discard_free: assert property (write_discard |=> !busy && !write_commit)
        else $error("protected write started a cycle");
    a_pulse_single: assert property ((write_commit || write_discard) |=>
        !(write_commit || write_discard)) else $error("stop pulse too long");
    a_load_single: assert property (read_load |=> !read_load)
        else $error("load pulse too long");
    a_busy_length: assert property ($fell(busy) |-> busy_cnt == WRITE_CYCLE_CLKS)
        else $error("write cycle length wrong");
endmodule : eeprom_front_end_properties
bind eeprom_two_wire_client_front_end eeprom_front_end_properties #(
    .WRITE_CYCLE_CLKS(WRITE_CYCLE_CLKS)) u_props (.clk_sys, .rst, .scl_in,
    .sda_out, .sda_oe, .read_load, .write_commit, .write_discard, .busy);
`default_nettype wire

// file: eeprom_two_wire_client_front_end.sv
// two-wire client front end with its write-data fifo
// assumes serial pins and straps are asynchronous to clk_sys and that
// read_data always shows the byte at word_addr
`timescale 1ns/100ps
`default_nettype none

module write_word_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W:0]   wr_ptr_reg;
    logic [PTR_W:0]   rd_ptr_reg;
    wire              fifo_empty;
    wire              fifo_full;
    wire              do_push;
    wire              do_pop;

    assign fifo_empty = (wr_ptr_reg == rd_ptr_reg);
    assign fifo_full  = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
                        (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
    assign in_ready   = ~fifo_full;
    assign out_valid  = ~fifo_empty;
    assign do_push    = clk_en & in_valid & ~fifo_full;
    assign do_pop     = clk_en & out_ready & ~fifo_empty;
    assign out_data   = mem_reg[rd_ptr_reg[PTR_W-1:0]];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (do_push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (do_pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    // storage needs no reset; valid is carried by the pointers
    always_ff @(posedge clk_sys) begin
        if (do_push) mem_reg[wr_ptr_reg[PTR_W-1:0]] <= in_data;
    end

endmodule : write_word_fifo

module eeprom_two_wire_client_front_end #(
    parameter logic [eeprom_front_end_pkg::TIMER_W-1:0] WRITE_CYCLE_CLKS =
        eeprom_front_end_pkg::TIMER_W'(eeprom_front_end_pkg::WRITE_CYCLE_CLKS)
) (
    input  wire logic                                   clk_sys,
    input  wire logic                                   rst,
    input  wire logic                                   clk_en,
    input  wire logic                                   scl_in,
    input  wire logic                                   sda_in,
    output logic                                        sda_out,
    output logic                                        sda_oe,
    input  wire logic                                   chip_select_pin_low,
    input  wire logic                                   chip_select_pin_mid,
    input  wire logic                                   chip_select_pin_high,
    input  wire logic                                   write_protect,
    input  wire logic                                   single_select_mode,
    input  wire logic [7:0]                             read_data,
    output logic                                        read_load,
    output logic [eeprom_front_end_pkg::ADDR_W-1:0]     word_addr,
    output logic                                        wr_valid,
    input  wire logic                                   wr_ready,
    output eeprom_front_end_pkg::wr_word_t              wr_word,
    output logic                                        write_commit,
    output logic                                        write_discard,
    output logic                                        busy
);
    // pin synchroniser: s1 feeds only s2
    logic [eeprom_front_end_pkg::SYNC_W-1:0] sync1_reg;
    logic [eeprom_front_end_pkg::SYNC_W-1:0] sync2_reg;
    logic [eeprom_front_end_pkg::SYNC_W-1:0] sync3_reg;
    logic [eeprom_front_end_pkg::SYNC_W-1:0] filt_reg;
    logic                                    scl_prev_reg;
    logic                                    sda_prev_reg;
    wire  [eeprom_front_end_pkg::SYNC_W-1:0] pins_raw;

    assign pins_raw = {single_select_mode, write_protect, chip_select_pin_high,
                       chip_select_pin_mid, chip_select_pin_low, sda_in, scl_in};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            sync3_reg <= '1;
        end else if (clk_en) begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < eeprom_front_end_pkg::SYNC_W; gi++) begin : g_filt
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst)
                    filt_reg[gi] <= 1'b1;
                else if (clk_en && (sync2_reg[gi] == sync3_reg[gi]))
                    filt_reg[gi] <= sync3_reg[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else if (clk_en) begin
            scl_prev_reg <= filt_reg[eeprom_front_end_pkg::LANE_SCL];
            sda_prev_reg <= filt_reg[eeprom_front_end_pkg::LANE_SDA];
        end
    end

    wire scl_f;
    wire sda_f;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    assign scl_f     = filt_reg[eeprom_front_end_pkg::LANE_SCL];
    assign sda_f     = filt_reg[eeprom_front_end_pkg::LANE_SDA];
    assign scl_rise  = scl_f & ~scl_prev_reg;
    assign scl_fall  = ~scl_f & scl_prev_reg;
    assign start_det = scl_f & scl_prev_reg & ~sda_f & sda_prev_reg;
    assign stop_det  = scl_f & scl_prev_reg & sda_f & ~sda_prev_reg;

    // control byte decode
    eeprom_front_end_pkg::bus_state_t       state_reg;
    eeprom_front_end_pkg::bus_state_t       state_next;
    eeprom_front_end_pkg::byte_kind_t       kind_reg;
    eeprom_front_end_pkg::byte_kind_t       kind_next;
    logic [2:0]                             bit_cnt_reg;
    logic [2:0]                             bit_cnt_next;
    logic [7:0]                             shift_reg;
    logic [7:0]                             shift_next;
    logic [eeprom_front_end_pkg::ADDR_W-1:0] addr_reg;
    logic [eeprom_front_end_pkg::ADDR_W-1:0] addr_next;
    logic                                   rw_reg;
    logic                                   rw_next;
    logic                                   full_reg;
    logic                                   full_next;
    logic                                   oe_reg;
    logic                                   oe_next;
    logic                                   got_data_reg;
    logic                                   got_data_next;
    logic [eeprom_front_end_pkg::TIMER_W-1:0] timer_reg;
    logic [eeprom_front_end_pkg::TIMER_W-1:0] timer_next;
    logic                                   commit_reg;
    logic                                   commit_next;
    logic                                   discard_reg;
    logic                                   discard_next;
    logic                                   rload_reg;
    logic                                   rload_next;
    logic                                   push;
    wire                                    fifo_in_ready;
    wire                                    type_match;
    wire                                    cs_match;
    wire                                    ctrl_match;
    wire                                    busy_now;
    wire                                    ack_ok;
    wire [eeprom_front_end_pkg::ADDR_W-1:0] addr_page_inc;
    eeprom_front_end_pkg::wr_word_t         push_word;

    assign type_match = (shift_reg[eeprom_front_end_pkg::CTRL_TYPE_MSB:
                                   eeprom_front_end_pkg::CTRL_TYPE_LSB] ==
                         eeprom_front_end_pkg::DEVICE_TYPE_CODE);
    // single variant ignores the two lower select bits
    assign cs_match =
        (shift_reg[eeprom_front_end_pkg::CTRL_CS_HIGH] ==
         filt_reg[eeprom_front_end_pkg::LANE_CS_HIGH]) &&
        (filt_reg[eeprom_front_end_pkg::LANE_SINGLE] ||
         ((shift_reg[eeprom_front_end_pkg::CTRL_CS_MID] ==
           filt_reg[eeprom_front_end_pkg::LANE_CS_MID]) &&
          (shift_reg[eeprom_front_end_pkg::CTRL_CS_LOW] ==
           filt_reg[eeprom_front_end_pkg::LANE_CS_LOW])));
    assign ctrl_match = type_match & cs_match;
    assign busy_now   = (timer_reg != '0);

    // a full fifo refuses the byte by withholding the acknowledge
    assign ack_ok = ~busy_now &&
                    ((kind_reg == eeprom_front_end_pkg::K_CTRL) ? ctrl_match :
                     (kind_reg == eeprom_front_end_pkg::K_DATA) ? fifo_in_ready :
                     1'b1);

    // page offset wraps so older bytes of the page are overwritten
    assign addr_page_inc = {addr_reg[eeprom_front_end_pkg::ADDR_W-1:
                                     eeprom_front_end_pkg::PAGE_BITS],
                            addr_reg[eeprom_front_end_pkg::PAGE_BITS-1:0] +
                            eeprom_front_end_pkg::PAGE_BITS'(1)};
    assign push_word.addr = addr_reg;
    assign push_word.data = shift_reg;

    always_comb begin
        state_next    = state_reg;
        kind_next     = kind_reg;
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        addr_next     = addr_reg;
        rw_next       = rw_reg;
        full_next     = full_reg;
        oe_next       = oe_reg;
        got_data_next = got_data_reg;
        timer_next    = busy_now ? timer_reg - 1'b1 : timer_reg;
        commit_next   = 1'b0;
        discard_next  = 1'b0;
        rload_next    = 1'b0;
        push          = 1'b0;
        if (start_det) begin
            // address is kept across a repeated start
            state_next    = eeprom_front_end_pkg::ST_RECV;
            kind_next     = eeprom_front_end_pkg::K_CTRL;
            bit_cnt_next  = 3'h0;
            full_next     = 1'b0;
            oe_next       = 1'b0;
            got_data_next = 1'b0;
        end else if (stop_det) begin
            state_next = eeprom_front_end_pkg::ST_IDLE;
            oe_next    = 1'b0;
            if (got_data_reg && !rw_reg) begin
                if (filt_reg[eeprom_front_end_pkg::LANE_WP]) begin
                    discard_next = 1'b1;
                end else begin
                    commit_next = 1'b1;
                    timer_next  = WRITE_CYCLE_CLKS;
                end
            end
        end else begin
            case (state_reg)
                eeprom_front_end_pkg::ST_RECV: begin
                    if (scl_rise) begin
                        shift_next   = {shift_reg[6:0], sda_f};
                        bit_cnt_next = bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == 3'(eeprom_front_end_pkg::BIT_LAST))
                            full_next = 1'b1;
                    end else if (scl_fall && full_reg) begin
                        full_next    = 1'b0;
                        bit_cnt_next = 3'h0;
                        if (ack_ok) begin
                            state_next = eeprom_front_end_pkg::ST_ACK;
                            oe_next    = 1'b1;
                            case (kind_reg)
                                eeprom_front_end_pkg::K_CTRL:
                                    rw_next = shift_reg[eeprom_front_end_pkg::CTRL_RW];
                                eeprom_front_end_pkg::K_ADDR_HI:
                                    addr_next[14:8] = shift_reg[6:0];
                                eeprom_front_end_pkg::K_ADDR_LO:
                                    addr_next[7:0] = shift_reg;
                                default: begin
                                    push          = 1'b1;
                                    got_data_next = 1'b1;
                                    addr_next     = addr_page_inc;
                                end
                            endcase
                        end else begin
                            state_next = eeprom_front_end_pkg::ST_IDLE;
                            oe_next    = 1'b0;
                        end
                    end
                end
                eeprom_front_end_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (kind_reg == eeprom_front_end_pkg::K_CTRL && rw_reg) begin
                            state_next = eeprom_front_end_pkg::ST_SEND;
                            shift_next = read_data;
                            oe_next    = ~read_data[7];
                            rload_next = 1'b1;
                            addr_next  = addr_reg + 1'b1;
                        end else begin
                            state_next = eeprom_front_end_pkg::ST_RECV;
                            oe_next    = 1'b0;
                            case (kind_reg)
                                eeprom_front_end_pkg::K_CTRL:
                                    kind_next = eeprom_front_end_pkg::K_ADDR_HI;
                                eeprom_front_end_pkg::K_ADDR_HI:
                                    kind_next = eeprom_front_end_pkg::K_ADDR_LO;
                                default:
                                    kind_next = eeprom_front_end_pkg::K_DATA;
                            endcase
                        end
                    end
                end
                eeprom_front_end_pkg::ST_SEND: begin
                    if (scl_fall) begin
                        bit_cnt_next = bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == 3'(eeprom_front_end_pkg::BIT_LAST)) begin
                            state_next = eeprom_front_end_pkg::ST_HOST_ACK;
                            oe_next    = 1'b0;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next    = ~shift_reg[6];
                        end
                    end
                end
                eeprom_front_end_pkg::ST_HOST_ACK: begin
                    if (scl_rise) begin
                        full_next = ~sda_f;
                    end else if (scl_fall) begin
                        full_next    = 1'b0;
                        bit_cnt_next = 3'h0;
                        if (full_reg) begin
                            state_next = eeprom_front_end_pkg::ST_SEND;
                            shift_next = read_data;
                            oe_next    = ~read_data[7];
                            rload_next = 1'b1;
                            addr_next  = addr_reg + 1'b1;
                        end else begin
                            // host nack ends the read with the line released
                            state_next = eeprom_front_end_pkg::ST_IDLE;
                        end
                    end
                end
                // idle: bits ignored until a start; a stop still commits or discards a pending write
                default: state_next = eeprom_front_end_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg    <= eeprom_front_end_pkg::ST_IDLE;
            kind_reg     <= eeprom_front_end_pkg::K_CTRL;
            bit_cnt_reg  <= 3'h0;
            shift_reg    <= 8'h00;
            addr_reg     <= '0;
            rw_reg       <= 1'b0;
            full_reg     <= 1'b0;
            oe_reg       <= 1'b0;
            got_data_reg <= 1'b0;
            timer_reg    <= '0;
            commit_reg   <= 1'b0;
            discard_reg  <= 1'b0;
            rload_reg    <= 1'b0;
        end else if (clk_en) begin
            state_reg    <= state_next;
            kind_reg     <= kind_next;
            bit_cnt_reg  <= bit_cnt_next;
            shift_reg    <= shift_next;
            addr_reg     <= addr_next;
            rw_reg       <= rw_next;
            full_reg     <= full_next;
            oe_reg       <= oe_next;
            got_data_reg <= got_data_next;
            timer_reg    <= timer_next;
            commit_reg   <= commit_next;
            discard_reg  <= discard_next;
            rload_reg    <= rload_next;
        end
    end

    write_word_fifo #(
        .WIDTH ($bits(eeprom_front_end_pkg::wr_word_t)),
        .DEPTH (eeprom_front_end_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .clk_en    (clk_en),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_word),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_word)
    );

    // open drain: only ever pulls low
    assign sda_out       = 1'b0;
    assign sda_oe        = oe_reg;
    assign word_addr     = addr_reg;
    assign read_load     = rload_reg;
    assign write_commit  = commit_reg;
    assign write_discard = discard_reg;
    assign busy          = busy_now;

endmodule : eeprom_two_wire_client_front_end

`default_nettype wire

// file: tb_top.sv
// self-checking bench for the two-wire client front end
// host model on the pins; bench is memory and fifo consumer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // cycle must outlast the poll's control byte, about 200 clocks after the stop
    localparam logic [20:0] CYCLE = 21'h000190;
    localparam logic [7:0] CTRL_WR = {eeprom_front_end_pkg::DEVICE_TYPE_CODE, 3'h5, 1'h0};
    logic clk_sys, rst, scl, host_pull, sda, sda_out, sda_oe, write_protect;
    logic single_select_mode, read_load, wr_valid, wr_ready, write_commit;
    logic write_discard, busy, ack;
    logic [2:0] cs_pins;
    logic [7:0] rx, read_data;
    logic [14:0] word_addr;
    eeprom_front_end_pkg::wr_word_t wr_word;
    int err_count, total_checks, n_commit, n_discard, n_load;
    assign sda = !(sda_oe || host_pull);
    assign read_data = word_addr[7:0] ^ 8'h3c;
    always @(posedge clk_sys) begin
        n_commit <= n_commit + int'(write_commit);
        n_discard <= n_discard + int'(write_discard);
        n_load <= n_load + int'(read_load);
    end
    two_wire_host u_host (.scl(scl), .sda_pull(host_pull), .sda(sda));
    eeprom_two_wire_client_front_end #(.WRITE_CYCLE_CLKS(CYCLE)) u_dut (.clk_sys, .rst,
        .clk_en(1'b1), .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
        .chip_select_pin_low(cs_pins[0]), .chip_select_pin_mid(cs_pins[1]),
        .chip_select_pin_high(cs_pins[2]), .write_protect, .single_select_mode,
        .read_data, .read_load, .word_addr, .wr_valid, .wr_ready, .wr_word,
        .write_commit, .write_discard, .busy);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic send(input logic [7:0] b, input logic exp_ack, input string what);
        u_host.xfer(b, 1'b0, rx, ack);
        check(what, {31'h0, ack}, {31'h0, exp_ack});
    endtask : send
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        {rst, write_protect, single_select_mode, wr_ready} = 4'h8;
        cs_pins = 3'h5;
        {err_count, total_checks} = '0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 u_host.start_cond();
        send(CTRL_WR ^ 8'h80, 1'b0, "type");
        u_host.start_cond();
        send(CTRL_WR ^ 8'h04, 1'b0, "select");
        u_host.start_cond();
        send(CTRL_WR, 1'b1, "ctrl");
        send(8'hff, 1'b1, "addr hi");
        send(8'h3f, 1'b1, "addr lo");
        for (int i = 0; i < 5; i++) send(8'(8'ha0 + i), i < 4, "data");
        u_host.stop_cond();
        check("commit", n_commit, 1);
        u_host.start_cond();
        send(CTRL_WR, 1'b0, "poll");
        u_host.stop_cond();
        for (int i = 0; i < 4; i++) begin
            check("word", 32'(wr_word), 32'({i == 0 ? 15'h7f3f : 15'h7f00 + 15'(i - 1), 8'(8'ha0 + i)}));
            @(posedge clk_sys) wr_ready <= 1'b1;
            @(posedge clk_sys) wr_ready <= 1'b0;
            #1;
        end
        check("drained", {31'h0, wr_valid}, 32'h0);
        for (int i = 0; i < 400 && busy === 1'b1; i++) @(posedge clk_sys);
        check("busy done", {31'h0, busy}, 32'h0);
        if (busy !== 1'b0)
            conclude();
        @(posedge clk_sys) write_protect <= 1'b1;
        single_select_mode <= 1'b1;
        #1 u_host.start_cond();
        send(CTRL_WR ^ 8'h02, 1'b1, "single");
        for (int i = 0; i < 3; i++) send(8'h77, 1'b1, "protected");
        u_host.stop_cond();
        check("discard", n_discard, 1);
        check("no cycle", {31'h0, busy}, 32'h0);
        u_host.start_cond();
        send(CTRL_WR ^ 8'h02, 1'b1, "random");
        send(8'h01, 1'b1, "addr hi");
        send(8'h45, 1'b1, "addr lo");
        u_host.start_cond();
        send(CTRL_WR ^ 8'h03, 1'b1, "read ctrl");
        u_host.xfer(8'hff, 1'b1, rx, ack);
        check("rd0", {24'h0, rx}, 32'h79);
        u_host.xfer(8'hff, 1'b0, rx, ack);
        check("rd1", {24'h0, rx}, 32'h7a);
        // wait past the point where a wrongly continued read would pull again
        repeat (8) @(posedge clk_sys);
        #1 check("released", {31'h0, sda_oe}, 32'h0);
        u_host.stop_cond();
        check("loads", n_load, 2);
        conclude();
    end
endmodule : tb_top
`default_nettype wire

// file: two_wire_host.sv
// bus host model: makes the clock, conditions and bytes, 80 ns period
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/100ps
`default_nettype none
module two_wire_host (
    output logic     scl,
    output logic     sda_pull,
    input wire logic sda
);
    localparam int HALF = 40;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic start_cond();
        sda_pull = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda_pull = 1'b1;
        #HALF scl = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        sda_pull = 1'b1;
        #HALF scl = 1'b1;
        #HALF sda_pull = 1'b0;
        #HALF;
    endtask : stop_cond
    // hack high pulls the ninth bit; ack reports the wire low there
    task automatic xfer(input logic [7:0] tx, input logic hack,
                        output logic [7:0] rx, output logic ack);
        logic [8:0] bits;
        logic [8:0] got;
        bits = {~tx, hack};
        for (int i = 8; i >= 0; i--) begin
            sda_pull = bits[i];
            #HALF scl = 1'b1;
            #(HALF/2) got[i] = sda;
            #(HALF/2) scl = 1'b0;
        end
        rx = got[8:1];
        ack = !got[0];
    endtask : xfer
endmodule : two_wire_host
`default_nettype wire
